// *** cpurf_pkg.sv ***
// Package with constants, types and enumerations for the core register file.
package cpurf_pkg;
  localparam int NUM_WORD_REGS = 8;
  localparam int SP_INDEX = 7;
  localparam int CCR_I = 7;
  localparam int CCR_U6 = 6;
  localparam int CCR_H = 5;
  localparam int CCR_U4 = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [7:0] BCD_MAX_BYTE = 8'h99;
  localparam logic [7:0] BCD_ADJ_LO = 8'h06;
  localparam logic [7:0] BCD_ADJ_HI = 8'h60;

  typedef enum logic [4:0] {
    op_none, op_add, op_addx, op_sub, op_subx, op_cmp, op_neg, op_mov,
    op_address_add_instr, op_address_sub_instr, op_mul, op_div, op_shl, op_shr, op_band, op_bor,
    op_bxor, op_bld, op_bst, op_daa, op_das
  } cpurf_op_t;

  typedef enum logic [2:0] {
    ccr_none, ccr_load, ccr_and, ccr_or, ccr_xor, ccr_pop
  } cpurf_ccr_op_t;

  typedef enum logic {st_vector, st_run} cpurf_state_t;

  // Register select: bits 2..0 pick the pair, bit 3 picks the lower byte.
  typedef struct packed {
    logic en;
    logic word;
    logic [3:0] idx;
    logic [15:0] data;
  } cpurf_wr_t;

  typedef struct packed {
    cpurf_op_t op;
    logic word;
    logic [3:0] dst;
    logic [15:0] a;
    logic [15:0] b;
    logic [2:0] bitn;
  } cpurf_alu_t;
endpackage : cpurf_pkg

// *** cpurf_core.sv ***
// Register file, program counter and condition flags of the core.
`timescale 1ns/1ns
`default_nettype none
module cpurf_core
  import cpurf_pkg::*;
(
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Reset vector fetch.
  input wire logic i_vec_valid,
  input wire logic [15:0] i_vec_data,
  output logic o_vec_req,
  output logic [15:0] o_vec_addr,
  // Register access.
  input wire cpurf_pkg::cpurf_wr_t i_wr,
  input wire logic [3:0] i_rd_sel,
  input wire logic i_rd_word,
  input wire logic [2:0] i_addr_sel,
  output logic [15:0] o_rd_data,
  output logic [15:0] o_addr,
  // Stack pointer adjust.
  input wire logic i_sp_push,
  input wire logic i_sp_pop,
  output logic [15:0] o_sp,
  // Program counter.
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_val,
  input wire logic i_pc_inc,
  output logic [15:0] o_pc,
  // Arithmetic and flags.
  input wire cpurf_pkg::cpurf_alu_t i_alu,
  input wire cpurf_pkg::cpurf_ccr_op_t i_ccr_op,
  input wire logic [15:0] i_ccr_val,
  input wire logic i_exc_start,
  input wire logic [3:0] i_cond,
  output logic [15:0] o_alu_res,
  output logic [7:0] o_ccr,
  output logic [15:0] o_ccr_word,
  output logic o_cond_true
);
  import cpurf_pkg::*;

  logic [15:0] gpr [NUM_WORD_REGS];
  logic [7:0] condition_code_flags;
  logic [15:0] pc;
  cpurf_state_t state;
  logic [15:0] opa;
  logic [15:0] opb;
  logic sub_op;
  logic ci;
  logic [8:0] sb;
  logic [4:0] hb;
  logic [16:0] sw;
  logic [12:0] hw;
  logic [15:0] res;
  logic [7:0] next_ccr;
  logic alu_wr;
  logic alu_word;
  logic flag_upd;
  logic lo_adj;
  logic hi_adj;
  logic sel_bit;
  cpurf_wr_t wr;
  logic next_cond;

  // Shared adder for add, subtract, compare and negate.
  always_comb
  begin
    sub_op = i_alu.op inside {op_sub, op_subx, op_cmp, op_neg};
    opa = (i_alu.op == op_neg) ? 16'h0000 : i_alu.a;
    opb = (i_alu.op == op_neg) ? i_alu.a : i_alu.b;
    if (sub_op)
    begin
      opb = ~opb;
    end
    if (i_alu.op inside {op_addx, op_subx})
    begin
      ci = condition_code_flags[CCR_C] ^ sub_op;
    end
    else
    begin
      ci = sub_op;
    end
    sb = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, ci};
    hb = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
    sw = {1'b0, opa} + {1'b0, opb} + {16'h0000, ci};
    hw = {1'b0, opa[11:0]} + {1'b0, opb[11:0]} + {12'h000, ci};
  end

  // Result and flag computation for each operation.
  always_comb
  begin
    res = 16'h0000;
    next_ccr = condition_code_flags;
    alu_wr = 1'b0;
    alu_word = i_alu.word;
    flag_upd = 1'b0;
    lo_adj = 1'b0;
    hi_adj = 1'b0;
    sel_bit = i_alu.a[i_alu.bitn];
    unique case (i_alu.op)
      op_add, op_addx, op_sub, op_subx, op_cmp, op_neg:
      begin
        alu_wr = (i_alu.op != op_cmp);
        flag_upd = 1'b1;
        if (i_alu.word && !(i_alu.op inside {op_addx, op_subx, op_neg}))
        begin
          res = sw[15:0];
          next_ccr[CCR_H] = hw[12] ^ sub_op;
          next_ccr[CCR_C] = sw[16] ^ sub_op;
          next_ccr[CCR_V] = (opa[15] == opb[15]) && (res[15] != opa[15]);
        end
        else
        begin
          alu_word = 1'b0;
          res = {8'h00, sb[7:0]};
          next_ccr[CCR_H] = hb[4] ^ sub_op;
          next_ccr[CCR_C] = sb[8] ^ sub_op;
          next_ccr[CCR_V] = (opa[7] == opb[7]) && (res[7] != opa[7]);
        end
      end
      op_mov:
      begin
        alu_wr = 1'b1;
        flag_upd = 1'b1;
        res = i_alu.word ? i_alu.a : {8'h00, i_alu.a[7:0]};
        next_ccr[CCR_V] = 1'b0;
      end
      op_address_add_instr, op_address_sub_instr:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b1;
        res = (i_alu.op == op_address_add_instr) ? i_alu.a + i_alu.b : i_alu.a - i_alu.b;
      end
      op_mul:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b1;
        res = {8'h00, i_alu.a[7:0]} * {8'h00, i_alu.b[7:0]};
      end
      op_div:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b1;
        if (i_alu.b[7:0] != 8'h00)
        begin
          res[7:0] = 8'(i_alu.a / {8'h00, i_alu.b[7:0]});
          res[15:8] = 8'(i_alu.a % {8'h00, i_alu.b[7:0]});
        end
      end
      op_shl, op_shr:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b0;
        flag_upd = 1'b1;
        next_ccr[CCR_V] = 1'b0;
        if (i_alu.op == op_shl)
        begin
          res = {8'h00, i_alu.a[6:0], 1'b0};
          next_ccr[CCR_C] = i_alu.a[7];
        end
        else
        begin
          res = {9'h000, i_alu.a[7:1]};
          next_ccr[CCR_C] = i_alu.a[0];
        end
      end
      op_band:
      begin
        next_ccr[CCR_C] = condition_code_flags[CCR_C] & sel_bit;
      end
      op_bor:
      begin
        next_ccr[CCR_C] = condition_code_flags[CCR_C] | sel_bit;
      end
      op_bxor:
      begin
        next_ccr[CCR_C] = condition_code_flags[CCR_C] ^ sel_bit;
      end
      op_bld:
      begin
        next_ccr[CCR_C] = sel_bit;
      end
      op_bst:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b0;
        res = {8'h00, i_alu.a[7:0]};
        res[i_alu.bitn] = condition_code_flags[CCR_C];
      end
      op_daa:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b0;
        flag_upd = 1'b1;
        lo_adj = condition_code_flags[CCR_H] || (i_alu.a[3:0] > BCD_MAX_DIGIT);
        hi_adj = condition_code_flags[CCR_C] || (i_alu.a[7:0] > BCD_MAX_BYTE);
        res[7:0] = i_alu.a[7:0] + (hi_adj ? BCD_ADJ_HI : 8'h00)
          + (lo_adj ? BCD_ADJ_LO : 8'h00);
        next_ccr[CCR_C] = hi_adj;
      end
      op_das:
      begin
        alu_wr = 1'b1;
        alu_word = 1'b0;
        flag_upd = 1'b1;
        res[7:0] = i_alu.a[7:0] - (condition_code_flags[CCR_C] ? BCD_ADJ_HI : 8'h00)
          - (condition_code_flags[CCR_H] ? BCD_ADJ_LO : 8'h00);
      end
      default:
      begin
        res = 16'h0000;
      end
    endcase
    if (flag_upd)
    begin
      next_ccr[CCR_N] = alu_word ? res[15] : res[7];
      next_ccr[CCR_Z] = alu_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
    end
  end

  // Write port: the arithmetic result takes precedence over the plain port.
  always_comb
  begin
    if (alu_wr)
    begin
      wr = '{en: 1'b1, word: alu_word, idx: i_alu.dst, data: res};
    end
    else
    begin
      wr = i_wr;
    end
  end

  // General registers hold no reset value.
  always_ff @(posedge i_core_clk)
  begin
    if (i_ce)
    begin
      if (wr.en && wr.word)
      begin
        gpr[wr.idx[2:0]] <= wr.data;
      end
      else if (wr.en && wr.idx[3])
      begin
        gpr[wr.idx[2:0]][7:0] <= wr.data[7:0];
      end
      else if (wr.en)
      begin
        gpr[wr.idx[2:0]][15:8] <= wr.data[7:0];
      end
      if (!(wr.en && wr.idx[2:0] == 3'(SP_INDEX)))
      begin
        if (i_sp_push)
        begin
          gpr[SP_INDEX] <= gpr[SP_INDEX] - SP_STEP;
        end
        else if (i_sp_pop)
        begin
          gpr[SP_INDEX] <= gpr[SP_INDEX] + SP_STEP;
        end
      end
    end
  end

  // Registered read ports.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rd_data <= 16'h0000;
      o_addr <= 16'h0000;
      o_sp <= 16'h0000;
    end
    else if (i_ce)
    begin
      if (i_rd_word)
      begin
        o_rd_data <= gpr[i_rd_sel[2:0]];
      end
      else if (i_rd_sel[3])
      begin
        o_rd_data <= {8'h00, gpr[i_rd_sel[2:0]][7:0]};
      end
      else
      begin
        o_rd_data <= {8'h00, gpr[i_rd_sel[2:0]][15:8]};
      end
      o_addr <= gpr[i_addr_sel];
      o_sp <= gpr[SP_INDEX];
    end
  end

  // Condition flags.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      condition_code_flags <= CCR_RESET;
    end
    else if (i_ce)
    begin
      unique case (i_ccr_op)
        ccr_none: condition_code_flags <= next_ccr;
        ccr_load: condition_code_flags <= i_ccr_val[7:0];
        ccr_and: condition_code_flags <= condition_code_flags & i_ccr_val[7:0];
        ccr_or: condition_code_flags <= condition_code_flags | i_ccr_val[7:0];
        ccr_xor: condition_code_flags <= condition_code_flags ^ i_ccr_val[7:0];
        ccr_pop: condition_code_flags <= i_ccr_val[15:8];
        default: condition_code_flags <= next_ccr;
      endcase
      if (i_exc_start)
      begin
        condition_code_flags[CCR_I] <= 1'b1;
      end
    end
  end

  // Branch condition evaluation.
  always_comb
  begin
    unique case (i_cond)
      4'h0: next_cond = 1'b1;
      4'h1: next_cond = 1'b0;
      4'h2: next_cond = !(condition_code_flags[CCR_C] | condition_code_flags[CCR_Z]);
      4'h3: next_cond = condition_code_flags[CCR_C] | condition_code_flags[CCR_Z];
      4'h4: next_cond = !condition_code_flags[CCR_C];
      4'h5: next_cond = condition_code_flags[CCR_C];
      4'h6: next_cond = !condition_code_flags[CCR_Z];
      4'h7: next_cond = condition_code_flags[CCR_Z];
      4'h8: next_cond = !condition_code_flags[CCR_V];
      4'h9: next_cond = condition_code_flags[CCR_V];
      4'ha: next_cond = !condition_code_flags[CCR_N];
      4'hb: next_cond = condition_code_flags[CCR_N];
      4'hc: next_cond = !(condition_code_flags[CCR_N] ^ condition_code_flags[CCR_V]);
      4'hd: next_cond = condition_code_flags[CCR_N] ^ condition_code_flags[CCR_V];
      4'he: next_cond = !(condition_code_flags[CCR_Z] | (condition_code_flags[CCR_N] ^ condition_code_flags[CCR_V]));
      4'hf: next_cond = condition_code_flags[CCR_Z] | (condition_code_flags[CCR_N] ^ condition_code_flags[CCR_V]);
    endcase
  end

  // Branch condition and arithmetic result outputs.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cond_true <= 1'b0;
      o_alu_res <= 16'h0000;
    end
    else if (i_ce)
    begin
      o_cond_true <= next_cond;
      o_alu_res <= res;
    end
  end

  assign o_ccr = condition_code_flags;
  assign o_ccr_word = {condition_code_flags, condition_code_flags};

  // Program counter and reset vector fetch.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= st_vector;
      pc <= 16'h0000;
      o_vec_req <= 1'b1;
      o_vec_addr <= RESET_VECTOR_ADDR;
    end
    else if (i_ce)
    begin
      unique case (state)
        st_vector:
        begin
          if (i_vec_valid)
          begin
            pc <= {i_vec_data[15:1], 1'b0};
            state <= st_run;
            o_vec_req <= 1'b0;
          end
        end
        st_run:
        begin
          if (i_pc_load)
          begin
            pc <= {i_pc_val[15:1], 1'b0};
          end
          else if (i_pc_inc)
          begin
            pc <= pc + PC_STEP;
          end
        end
      endcase
    end
  end

  assign o_pc = pc;

  property p_exc_mask;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_exc_start |=> condition_code_flags[CCR_I] && o_ccr[CCR_I];
  endproperty
  a_exc_mask: assert property (p_exc_mask) else $error("mask bit not set");

  property p_half_byte;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_alu.op == op_add && !i_alu.word && i_ccr_op == ccr_none
    |=> condition_code_flags[CCR_H] == (({1'b0, $past(i_alu.a[3:0])}
      + {1'b0, $past(i_alu.b[3:0])}) > 5'h0f);
  endproperty
  a_half_byte: assert property (p_half_byte) else $error("byte half carry");

  property p_carry_word;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_alu.op == op_add && i_alu.word && i_ccr_op == ccr_none
    |=> condition_code_flags[CCR_C] == (({1'b0, $past(i_alu.a)} + {1'b0, $past(i_alu.b)}) > 17'h0ffff);
  endproperty
  a_carry_word: assert property (p_carry_word) else $error("word carry");

  property p_zero;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_alu.op == op_sub && !i_alu.word && i_ccr_op == ccr_none
    |=> condition_code_flags[CCR_Z] == ($past(i_alu.a[7:0]) == $past(i_alu.b[7:0]));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");

  property p_vector;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && state == st_vector && i_vec_valid
    |=> o_pc == {$past(i_vec_data[15:1]), 1'b0} && !o_vec_req;
  endproperty
  a_vector: assert property (p_vector) else $error("vector load");

  property p_pc_load;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && state == st_run && i_pc_load |=> o_pc == {$past(i_pc_val[15:1]), 1'b0};
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("counter load");

  property p_sp_push;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_sp_push && !wr.en ##1 i_ce |=> o_sp == $past(o_sp) - SP_STEP;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("stack push");

  property p_user_bits;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_ccr_op == ccr_load && !i_exc_start
    |=> o_ccr[CCR_U6] == $past(i_ccr_val[6]) && o_ccr[CCR_U4] == $past(i_ccr_val[4]);
  endproperty
  a_user_bits: assert property (p_user_bits) else $error("user bits");

  property p_push_word;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_ccr_op == ccr_pop && !i_exc_start
    |=> o_ccr_word == {$past(i_ccr_val[15:8]), $past(i_ccr_val[15:8])};
  endproperty
  a_push_word: assert property (p_push_word) else $error("pushed flags");

  property p_cond_eq;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_cond == 4'h7 |=> o_cond_true == $past(condition_code_flags[CCR_Z]);
  endproperty
  a_cond_eq: assert property (p_cond_eq) else $error("branch condition");
endmodule : cpurf_core
`default_nettype wire

// *** cpu_register_file_and_flags_test.sv ***
// Self-checking testbench for the core register file, counter and flags.
`timescale 1ns/1ns
`default_nettype none
module cpu_register_file_and_flags_test;
  import cpurf_pkg::*;
  typedef struct packed {
    logic [3:0] sel;
    logic [15:0] exp;
  } cpurf_note_t;
  logic i_core_clk, i_rst_n, i_ce, i_vec_valid, o_vec_req, i_rd_word;
  logic i_sp_push, i_sp_pop, i_pc_load, i_pc_inc, i_exc_start, o_cond_true;
  logic [15:0] i_vec_data, o_vec_addr, o_rd_data, o_addr, o_sp, i_pc_val, o_pc;
  logic [15:0] i_ccr_val, o_alu_res, o_ccr_word;
  logic [3:0] i_rd_sel, i_cond;
  logic [2:0] i_addr_sel;
  logic [7:0] o_ccr;
  cpurf_wr_t i_wr;
  cpurf_alu_t i_alu;
  cpurf_ccr_op_t i_ccr_op;
  cpurf_note_t notes[$];
  cpurf_note_t nt;
  int fail_count;
  int tests_run;
  int k;
  int j;
  logic [15:0] wv [8];
  logic [33:0] av [8];
  logic [15:0] pc_m, sp_m, r_m, t, sv, u;
  cpurf_op_t oq [11];
  logic [7:0] cc_m, fl;

  cpurf_core dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_vec_valid(i_vec_valid), .i_vec_data(i_vec_data), .o_vec_req(o_vec_req),
    .o_vec_addr(o_vec_addr), .i_wr(i_wr), .i_rd_sel(i_rd_sel), .i_rd_word(i_rd_word),
    .i_addr_sel(i_addr_sel), .o_rd_data(o_rd_data), .o_addr(o_addr),
    .i_sp_push(i_sp_push), .i_sp_pop(i_sp_pop), .o_sp(o_sp), .i_pc_load(i_pc_load),
    .i_pc_val(i_pc_val), .i_pc_inc(i_pc_inc), .o_pc(o_pc), .i_alu(i_alu),
    .i_ccr_op(i_ccr_op), .i_ccr_val(i_ccr_val), .i_exc_start(i_exc_start),
    .i_cond(i_cond), .o_alu_res(o_alu_res), .o_ccr(o_ccr), .o_ccr_word(o_ccr_word),
    .o_cond_true(o_cond_true)
  );

  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Each note names the output to look at and the value it must hold.
  always @(negedge i_core_clk)
  begin
    while (notes.size() > 0)
    begin
      nt = notes.pop_front();
      case (nt.sel)
        4'h0: sv = o_rd_data;
        4'h1: sv = o_addr;
        4'h2: sv = o_sp;
        4'h3: sv = o_pc;
        4'h4: sv = {8'h00, o_ccr};
        4'h5: sv = o_alu_res;
        4'h6: sv = o_ccr_word;
        4'h7: sv = {15'h0000, o_cond_true};
        4'h8: sv = {15'h0000, o_vec_req};
        4'h9: sv = {15'h0000, o_ccr[CCR_C]};
        4'ha: sv = {8'h00, o_alu_res[7:0]};
        default: sv = o_vec_addr;
      endcase
      check(sv, nt.exp);
    end
  end

  task automatic note(input logic [3:0] s, input logic [15:0] e);
    notes.push_back('{s, e});
  endtask : note

  // Lets the staged request be taken, notes the result, then idles one cycle.
  task automatic go(input logic [3:0] s, input logic [15:0] e);
    @(posedge i_core_clk);
    if (s != 4'hf)
      note(s, e);
    i_wr.en <= 1'b0;
    i_sp_push <= 1'b0;
    i_sp_pop <= 1'b0;
    i_pc_load <= 1'b0;
    i_pc_inc <= 1'b0;
    i_alu.op <= op_none;
    i_ccr_op <= ccr_none;
    i_exc_start <= 1'b0;
    i_ce <= 1'b1;
    @(posedge i_core_clk);
  endtask : go

  task automatic ld_ccr(input logic [7:0] v);
    cc_m = v;
    i_ccr_op <= ccr_load;
    i_ccr_val <= {8'h00, v};
    go(4'h4, {8'h00, v});
  endtask : ld_ccr

  function automatic logic [7:0] arith(input logic [7:0] c, input logic w, input logic s,
      input logic [15:0] a, input logic [15:0] b, output logic [15:0] r);
    logic [16:0] f;
    logic [12:0] lo;
    logic [15:0] bb;
    logic h;
    logic v;
    bb = s ? ~b : b;
    if (w)
    begin
      f = {1'b0, a} + {1'b0, bb} + {16'h0000, s};
      lo = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, s};
      r = f[15:0];
      h = lo[12];
      v = (a[15] == bb[15]) && (r[15] != a[15]);
    end
    else
    begin
      f = {9'h000, a[7:0]} + {9'h000, bb[7:0]} + {16'h0000, s};
      lo = {9'h000, a[3:0]} + {9'h000, bb[3:0]} + {12'h000, s};
      r = {8'h00, f[7:0]};
      f[16] = f[8];
      h = lo[4];
      v = (a[7] == bb[7]) && (r[7] != a[7]);
    end
    return {c[7:6], h ^ s, c[4], w ? r[15] : r[7], r == 16'h0000, v, f[16] ^ s};
  endfunction : arith

  function automatic logic cond_f(input logic [3:0] c, input logic [7:0] f);
    logic n, z, v, y;
    logic [15:0] tb;
    n = f[CCR_N];
    z = f[CCR_Z];
    v = f[CCR_V];
    y = f[CCR_C];
    tb = {z | (n ^ v), !z && !(n ^ v), n ^ v, !(n ^ v), n, !n, v, !v, z, !z, y, !y,
      y | z, !(y | z), 1'b0, 1'b1};
    return tb[c];
  endfunction : cond_f

  task automatic run_body();
    i_vec_valid <= 1'b0;
    pc_m = i_vec_data & 16'hfffe;
    go(4'h3, pc_m);
    i_pc_inc <= 1'b1;
    pc_m = pc_m + PC_STEP;
    go(4'h3, pc_m);
    t = 16'($urandom) | 16'h0001;
    i_pc_val <= t;
    i_pc_load <= 1'b1;
    i_pc_inc <= 1'b1;
    pc_m = t & 16'hfffe;
    go(4'h3, pc_m);
    i_ce <= 1'b0;
    i_pc_inc <= 1'b1;
    go(4'h3, pc_m);
    for (k = 0; k < 8; k++)
    begin
      wv[k] = 16'($urandom);
      i_wr <= '{1'b1, 1'b1, 4'(k), wv[k]};
      go(4'hf, 16'h0000);
    end
    for (k = 0; k < 8; k++)
    begin
      i_rd_sel <= 4'(k);
      i_rd_word <= 1'b1;
      i_addr_sel <= 3'(k);
      go(4'h0, wv[k]);
      note(4'h1, wv[k]);
    end
    t = 16'($urandom);
    i_wr <= '{1'b1, 1'b0, 4'ha, t};
    go(4'hf, 16'h0000);
    i_wr <= '{1'b1, 1'b0, 4'h2, ~t};
    go(4'hf, 16'h0000);
    wv[2] = {~t[7:0], t[7:0]};
    i_rd_sel <= 4'h2;
    go(4'h0, wv[2]);
    i_rd_word <= 1'b0;
    go(4'h0, {8'h00, wv[2][15:8]});
    i_rd_sel <= 4'ha;
    go(4'h0, {8'h00, wv[2][7:0]});
    sp_m = wv[7];
    note(4'h2, sp_m);
    i_sp_push <= 1'b1;
    i_sp_pop <= 1'b1;
    sp_m = sp_m - SP_STEP;
    go(4'hf, 16'h0000);
    go(4'h2, sp_m);
    i_sp_pop <= 1'b1;
    sp_m = sp_m + SP_STEP;
    go(4'hf, 16'h0000);
    go(4'h2, sp_m);
    ld_ccr(8'($urandom));
    note(4'h6, {cc_m, cc_m});
    for (k = 0; k < 3; k++)
    begin
      t = 16'($urandom);
      i_ccr_op <= (k == 0) ? ccr_and : (k == 1) ? ccr_or : ccr_xor;
      i_ccr_val <= t;
      cc_m = (k == 0) ? cc_m & t[7:0] : (k == 1) ? cc_m | t[7:0] : cc_m ^ t[7:0];
      go(4'h4, {8'h00, cc_m});
    end
    t = 16'($urandom);
    i_ccr_op <= ccr_pop;
    i_ccr_val <= t;
    go(4'h4, {8'h00, t[15:8]});
    i_ccr_op <= ccr_load;
    i_ccr_val <= 16'h0000;
    i_exc_start <= 1'b1;
    go(4'h4, 16'h0080);
    for (j = 0; j < 4; j++)
    begin
      ld_ccr(8'($urandom));
      for (k = 0; k < 16; k++)
      begin
        i_cond <= 4'(k);
        go(4'h7, {15'h0000, cond_f(4'(k), cc_m)});
      end
    end
    av = '{{2'b00, 16'h000f, 16'h0001}, {2'b00, 16'h007f, 16'h0001},
      {2'b00, 16'h00ff, 16'h0001}, {2'b01, 16'h0000, 16'h0001},
      {2'b01, 16'h0080, 16'h0001}, {2'b10, 16'h0fff, 16'h0001},
      {2'b11, 16'h8000, 16'h0001}, {2'b10, 16'hffff, 16'h0001}};
    for (k = 0; k < 10; k++)
    begin
      if (k >= 8)
        av[k - 8] = {k == 9, k == 9, 16'($urandom), 16'($urandom)};
      ld_ccr(8'($urandom));
      fl = arith(cc_m, av[k % 8][33], av[k % 8][32], av[k % 8][31:16], av[k % 8][15:0], r_m);
      i_alu <= '{av[k % 8][32] ? op_sub : op_add, av[k % 8][33], av[k % 8][33] ? 4'h1 : 4'h9,
        av[k % 8][31:16], av[k % 8][15:0], 3'h0};
      go(av[k % 8][33] ? 4'h5 : 4'ha, r_m);
      note(4'h4, {8'h00, fl});
      i_rd_sel <= av[k % 8][33] ? 4'h1 : 4'h9;
      i_rd_word <= av[k % 8][33];
      go(4'h0, r_m);
    end
    ld_ccr(8'h00);
    i_alu <= '{op_shl, 1'b0, 4'h9, 16'h0081, 16'h0000, 3'h0};
    go(4'ha, 16'h0002);
    note(4'h9, 16'h0001);
    for (k = 0; k < 2; k++)
    begin
      ld_ccr(8'($urandom));
      t = 16'($urandom);
      fl = arith(cc_m, 1'b0, 1'b1, (k == 0) ? t : 16'h0000, t, r_m);
      i_alu <= '{(k == 0) ? op_cmp : op_neg, 1'b0, 4'h9, t, t, 3'h0};
      go(4'h4, {8'h00, fl});
    end
    oq = '{op_mul, op_address_add_instr, op_address_sub_instr, op_bst, op_das, op_daa, op_shr, op_band, op_bor, op_bxor,
      op_bld};
    // Both carry and half carry are set first, so decimal adjust applies both digit corrections.
    for (k = 0; k < 7; k++)
    begin
      t = 16'($urandom);
      u = 16'($urandom);
      ld_ccr(8'h21);
      case (k)
        0: r_m = 16'(t[7:0]) * 16'(u[7:0]);
        1: r_m = t + u;
        2: r_m = t - u;
        3: r_m = {8'h00, t[7:0] | (8'h01 << u[2:0])};
        4: r_m = {8'h00, t[7:0] - 8'h66};
        5: r_m = {8'h00, t[7:0] + 8'h66};
        default: r_m = {9'h000, t[7:1]};
      endcase
      i_alu <= '{oq[k], 1'b0, 4'h9, t, u, u[2:0]};
      go(4'h5, r_m);
    end
    for (k = 0; k < 8; k++)
    begin
      t = 16'($urandom);
      ld_ccr({7'h00, t[8]});
      i_alu <= '{oq[7 + k % 4], 1'b0, 4'h9, t, 16'h0000, 3'(k)};
      fl[0] = (k % 4 == 0) ? t[8] & t[k] : (k % 4 == 1) ? t[8] | t[k]
        : (k % 4 == 2) ? t[8] ^ t[k] : t[k];
      go(4'h9, {15'h0000, fl[0]});
    end
  endtask : run_body

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    t = 16'($urandom(32'h5e06));
    {i_rd_word, i_sp_push, i_sp_pop, i_pc_load, i_pc_inc, i_exc_start} = 6'h00;
    {i_pc_val, i_ccr_val, i_rd_sel, i_cond, i_addr_sel} = 43'h0;
    i_wr = '0;
    i_alu = '{op_none, 1'b0, 4'h0, 16'h0000, 16'h0000, 3'h0};
    i_ccr_op = ccr_none;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_vec_valid = 1'b1;
    i_vec_data = 16'($urandom);
    @(posedge i_core_clk);
    note(4'h4, {8'h00, CCR_RESET});
    note(4'h8, 16'h0001);
    note(4'hb, RESET_VECTOR_ADDR);
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 10 && o_vec_req !== 1'b0; k++)
      @(negedge i_core_clk);
    if (o_vec_req !== 1'b0)
    begin
      fail_count++;
    end
    else
    begin
      @(posedge i_core_clk);
      run_body();
    end
    @(negedge i_core_clk);
    final_report();
  end
endmodule : cpu_register_file_and_flags_test
`default_nettype wire
